// ===== design/tcp_command_port.sv
/*
  Serial test command port with its coefficient bank, the 128-bit nonvolatile
  bit array and a conversion sequencer that streams observation words out.
  Assumes mclk is the tester-driven clock while test mode is high; the reset,
  test-mode and serial data pins come from the tester and are synchronised.
  The data line is delayed as far as the frame pin but not glitch-filtered.
*/
`timescale 1ns/1ps

module tcp_command_port
  import tcp_pkg::*;
#(
  parameter int unsigned OPC_LSB    = `TCP_OPC_LSB,
  parameter int unsigned RADDR_LSB  = `TCP_RADDR_LSB,
  parameter int unsigned NVADDR_LSB = `TCP_NVADDR_LSB,
  parameter int unsigned RDATA_LSB  = `TCP_RDATA_LSB,
  parameter bit          MSB_FIRST  = `TCP_MSB_FIRST,
  parameter logic [15:0] CONV_CYC   = `TCP_CONV_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        test_mode_pin,
  input  wire logic        frame_rstn_pin,
  input  wire logic        sdio_i,
  input  wire logic        adc_sample_valid,
  input  wire logic [16:0] adc_sample,
  input  wire logic        observe_ready,
  output logic             sdio_o,
  output logic             sdio_oe,
  output logic             serial_observe_out,
  output logic             serial_observe_oe,
  output logic [2:0]       bias_trim_setting,
  output logic [1:0]       front_gain_setting,
  output logic             amp_enable,
  output logic [2:0]       thermal_bias_trim,
  output logic             conv_busy,
  output logic             coeff_valid,
  output logic [15:0]      coeff_data,
  output logic [2:0]       coeff_index
);

  // Bits in one command word
  localparam int W = `TCP_WORD_BITS;

  // Reset values match a tester that holds the frame pin low at power-up
  // Three-stage synchronisers for tester pins; stage 1 feeds only stage 2
  logic [2:0] rst_sync_q;
  logic [2:0] tm_sync_q;
  logic [2:0] sd_sync_q;
  logic       frame_lvl_q;
  logic       tm_lvl_q;
  logic       sd_lvl_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 3'h0;
      tm_sync_q  <= 3'h0;
      sd_sync_q  <= 3'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[1:0], frame_rstn_pin};
      tm_sync_q  <= {tm_sync_q[1:0], test_mode_pin};
      sd_sync_q  <= {sd_sync_q[1:0], sdio_i};
    end
  end

  // A level change counts once stages two and three agree, which rejects a
  // one-clock glitch on the slow control pins
  wire rst_agree = (rst_sync_q[1] == rst_sync_q[2]);
  wire tm_agree  = (tm_sync_q[1] == tm_sync_q[2]);
  // The data line is exempt: each command bit lasts a single clock, and the
  // agreement filter would swallow every bit that differs from both its neighbours.
  // It still passes as many stages, so data and frame stay aligned.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frame_lvl_q <= 1'b0;
      tm_lvl_q    <= 1'b0;
      sd_lvl_q    <= 1'b0;
    end else begin
      if (rst_agree) frame_lvl_q <= rst_sync_q[2];
      if (tm_agree) tm_lvl_q <= tm_sync_q[2];
      sd_lvl_q <= sd_sync_q[2];
    end
  end

  // Frame edges; the frame pin low in test mode also clears the bank
  logic frame_prev_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) frame_prev_q <= 1'b0;
    else frame_prev_q <= frame_lvl_q;
  end
  wire frame_rise = frame_lvl_q & ~frame_prev_q & tm_lvl_q;
  wire frame_low  = ~frame_lvl_q;

  // Command receiver; the counter rests at 32 after a word and only a frame
  // low rearms it, so one frame carries at most one command.
  // Shift direction is a parameter; the default takes the top bit first
  tcp_rx_state_t rx_q;
  logic [W-1:0]  shift_q;
  logic [5:0]    bit_cnt_q;
  wire  [W-1:0]  shift_d = MSB_FIRST ? {shift_q[W-2:0], sd_lvl_q}
                                      : {sd_lvl_q, shift_q[W-1:1]};
  wire           last_bit = (bit_cnt_q == 6'(W - 1));
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_q      <= TCP_IDLE;
      shift_q   <= '0;
      bit_cnt_q <= 6'h00;
    end else if (frame_low) begin
      rx_q      <= TCP_IDLE;
      bit_cnt_q <= 6'h00;
    end else begin
      unique case (rx_q)
        TCP_IDLE: begin
          if (frame_rise) rx_q <= TCP_SHIFT;
        end
        TCP_SHIFT: begin
          shift_q   <= shift_d;
          bit_cnt_q <= bit_cnt_q + 6'h01;
          if (last_bit) rx_q <= TCP_EXEC;
        end
        TCP_EXEC: rx_q <= TCP_IDLE;
      endcase
    end
  end

  // Field split of the received word
  // Default placement puts the opcode in the last four bits shifted in
  wire [3:0]  opc    = shift_q[OPC_LSB +: `TCP_OPC_BITS];
  wire [2:0]  raddr  = shift_q[RADDR_LSB +: `TCP_RADDR_BITS];
  wire [6:0]  nvaddr = shift_q[NVADDR_LSB +: `TCP_NVADDR_BITS];
  wire [15:0] rdata  = shift_q[RDATA_LSB +: `TCP_RDATA_BITS];
  wire        exec   = (rx_q == TCP_EXEC);
  // Reserved codes fall through every decode and act as idle
  wire do_write  = exec & (opc == `TCP_OP_WRITE_REG);
  wire do_set    = exec & (opc == `TCP_OP_NV_SET);
  wire do_erase  = exec & (opc == `TCP_OP_NV_ERASE);
  wire do_start  = exec & opc[`TCP_OPC_START_BIT] & ~opc[0];
  wire do_reload = do_start & opc[`TCP_OPC_RELOAD_BIT];
  wire obs_on    = ~opc[`TCP_OPC_OBS_OFF_BIT];

  // Nonvolatile bits: each set or erase takes one command, repeats are harmless
  // No single-bit clear exists; only the whole-array erase or rstn returns bits to zero
  logic [`TCP_NV_BITS-1:0] nv_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) nv_q <= '0;
    else if (do_erase) nv_q <= '0;
    else if (do_set) nv_q[nvaddr] <= 1'b1;
  end

  // Coefficient bank; a frame low with test mode clears it on every clock,
  // so a write is lost at the next frame, before any conversion can start
  logic [15:0] bank_q [`TCP_NUM_REGS];
  tcp_conv_state_t cv_q;
  logic [2:0]      ld_idx_q;
  logic [15:0]     cyc_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `TCP_NUM_REGS; i++) bank_q[i] <= `TCP_REG_RESET;
    end else if (frame_low && tm_lvl_q) begin
      for (int i = 0; i < `TCP_NUM_REGS; i++) bank_q[i] <= `TCP_REG_RESET;
    end else if (do_write) begin
      bank_q[raddr] <= rdata;
    end else if (cv_q == TCP_CV_LOAD) begin
      bank_q[ld_idx_q] <= nv_q[ld_idx_q*16 +: 16];
    end
  end

  // Configuration fields steer the front end
  // Registered, so the front end sees a change one clock after the bank
  wire [15:0] cfg = bank_q[`TCP_CFG_SETTINGS];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bias_trim_setting  <= 3'h0;
      front_gain_setting <= 2'h0;
      amp_enable         <= 1'b0;
      thermal_bias_trim  <= 3'h0;
    end else begin
      bias_trim_setting  <= cfg[`TCP_CFG_BIAS_LSB +: 3];
      front_gain_setting <= cfg[`TCP_CFG_GAIN_LSB +: 2];
      amp_enable         <= cfg[`TCP_CFG_AMP_BIT];
      thermal_bias_trim  <= cfg[`TCP_CFG_TBIAS_LSB +: 3];
    end
  end

  // Saturate the sample to the 16-bit full scale
  // A guard bit unlike the sign means the input left the supply range
  wire        s_hi = ~adc_sample[16] & adc_sample[15];
  wire        s_lo = adc_sample[16] & ~adc_sample[15];
  wire [15:0] sample_sat = s_hi ? 16'h7FFF : s_lo ? 16'h8000 : adc_sample[15:0];
  logic [15:0] sample_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) sample_q <= 16'h0000;
    else if (adc_sample_valid) sample_q <= sample_sat;
  end

  // Conversion sequencer; a new start restarts it
  // Reload walks the eight registers one per clock before the run begins.
  // A frame low ends any conversion, a repeating one included
  logic obs_q;
  wire  conv_end = (cv_q == TCP_CV_RUN) && (cyc_q == CONV_CYC);
  wire  repeat_f = cfg[`TCP_CFG_REPEAT_BIT];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cv_q     <= TCP_CV_IDLE;
      ld_idx_q <= 3'h0;
      cyc_q    <= 16'h0000;
      obs_q    <= 1'b0;
    end else if (frame_low) begin
      cv_q  <= TCP_CV_IDLE;
      obs_q <= 1'b0;
    end else if (do_start) begin
      cv_q     <= do_reload ? TCP_CV_LOAD : TCP_CV_RUN;
      ld_idx_q <= 3'h0;
      cyc_q    <= 16'h0000;
      obs_q    <= obs_on;
    end else begin
      unique case (cv_q)
        TCP_CV_IDLE: ;
        TCP_CV_LOAD: begin
          ld_idx_q <= ld_idx_q + 3'h1;
          if (ld_idx_q == 3'h7) cv_q <= TCP_CV_RUN;
        end
        TCP_CV_RUN: begin
          cyc_q <= cyc_q + 16'h0001;
          if (conv_end) begin
            cyc_q <= 16'h0000;
            if (!repeat_f) cv_q <= TCP_CV_IDLE;
          end
        end
      endcase
    end
  end

  // Two-entry buffer of observation words: bank 0..7 then the sample
  // A word leaves when the output register is empty or taken this clock, so a
  // stall by the receiver keeps it here instead of dropping it.
  // Tags travel with the words; the sample word carries tag 0, the same as register 0
  logic [15:0] buf_q [2];
  logic [2:0]  buf_tag_q [2];
  logic [1:0]  buf_cnt_q;
  logic        wr_ptr_q;
  logic        rd_ptr_q;
  logic [3:0]  push_idx_q;
  wire  in_valid = (cv_q == TCP_CV_RUN) && obs_q && (push_idx_q != 4'h9);
  wire  in_ready = (buf_cnt_q != 2'h2);
  wire  push     = in_valid & in_ready;
  wire  pop      = (buf_cnt_q != 2'h0) & (observe_ready | ~coeff_valid);
  wire [15:0] push_word = push_idx_q[3] ? sample_q : bank_q[push_idx_q[2:0]];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      buf_cnt_q  <= 2'h0;
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      push_idx_q <= 4'h0;
      buf_q[0] <= 16'h0000;
      buf_q[1] <= 16'h0000;
      buf_tag_q[0] <= 3'h0;
      buf_tag_q[1] <= 3'h0;
    end else begin
      if (do_start || conv_end) push_idx_q <= 4'h0;
      else if (push) push_idx_q <= push_idx_q + 4'h1;
      if (push) begin
        buf_q[wr_ptr_q]     <= push_word;
        buf_tag_q[wr_ptr_q] <= push_idx_q[2:0];
        wr_ptr_q            <= ~wr_ptr_q;
      end
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Observation output register and serialiser of the current word
  // Valid drops only when the receiver takes the word and none follows.
  // The bit counter wraps freely; a new word always restarts it at the top bit
  logic [3:0] ser_bit_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      coeff_valid <= 1'b0;
      coeff_data  <= 16'h0000;
      coeff_index <= 3'h0;
      ser_bit_q   <= 4'h0;
    end else if (pop) begin
      coeff_valid <= 1'b1;
      coeff_data  <= buf_q[rd_ptr_q];
      coeff_index <= buf_tag_q[rd_ptr_q];
      ser_bit_q   <= 4'hF;
    end else begin
      if (observe_ready) coeff_valid <= 1'b0;
      ser_bit_q <= ser_bit_q - 4'h1;
    end
  end

  // Serial pin sources; both lines share one enable so they switch together.
  // Each pin lags the output word by one clock, the cost of registering it.
  // A frame low drops the enable one clock after the synchronised frame level falls, so the tester can take the line back
  wire cv_active = (cv_q != TCP_CV_IDLE);
  wire obs_drive = obs_q && cv_active && frame_lvl_q;
  wire tag_bit   = coeff_index[0] & coeff_valid;
  wire ser_bit   = coeff_data[ser_bit_q];

  // Serial pins driven only while observing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sdio_o             <= 1'b0;
      sdio_oe            <= 1'b0;
      serial_observe_out <= 1'b0;
      serial_observe_oe  <= 1'b0;
      conv_busy          <= 1'b0;
    end else begin
      sdio_oe            <= obs_drive;
      serial_observe_oe  <= obs_drive;
      serial_observe_out <= ser_bit;
      sdio_o             <= tag_bit;
      conv_busy          <= cv_active;
    end
  end

endmodule : tcp_command_port

// ===== design/tcp_regs.svh
/*
  Constants of the test command port: command word field positions, opcodes,
  configuration bit layout, coefficient bank shape and timing counts.
  Assumes nothing; definitions only.
*/
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

// Command word shape and default field placement, opcode last
`define TCP_WORD_BITS        32
`define TCP_OPC_LSB          0
`define TCP_OPC_BITS         4
`define TCP_RADDR_LSB        4
`define TCP_RADDR_BITS       3
`define TCP_NVADDR_LSB       8
`define TCP_NVADDR_BITS      7
`define TCP_RDATA_LSB        16
`define TCP_RDATA_BITS       16
`define TCP_MSB_FIRST        1'b1

// Opcodes
`define TCP_OP_IDLE          4'h0
`define TCP_OP_WRITE_REG     4'h1
`define TCP_OP_NV_SET        4'h2
`define TCP_OP_NV_ERASE      4'h4
`define TCP_OP_CONV_REG_OBS  4'h8
`define TCP_OP_CONV_NV_OBS   4'hA
`define TCP_OP_CONV_REG_QT   4'hC
`define TCP_OP_CONV_NV_QT    4'hE
`define TCP_OPC_OBS_OFF_BIT  2
`define TCP_OPC_RELOAD_BIT   1
`define TCP_OPC_START_BIT    3

// Coefficient bank: offsets are register numbers
`define TCP_NUM_REGS         8
`define TCP_REG_BITS         16
`define TCP_NV_BITS          128
`define TCP_CFG_SETTINGS     3'h0
`define TCP_SCALE_COEFF      3'h1
`define TCP_LIN_TC_SCALE     3'h2
`define TCP_QUAD_TC_SCALE    3'h3
`define TCP_BASE_OFFSET      3'h4
`define TCP_LIN_TC_OFFSET    3'h5
`define TCP_QUAD_TC_OFFSET   3'h6
`define TCP_OUT_PEDESTAL     3'h7
`define TCP_REG_RESET        16'h0000

// Configuration register layout
`define TCP_CFG_BIAS_LSB     0
`define TCP_CFG_GAIN_LSB     3
`define TCP_CFG_AMP_BIT      7
`define TCP_CFG_TBIAS_LSB    9
`define TCP_CFG_REPEAT_BIT   15

// Timing: reset held low, in clock periods; conversion length (own choice)
`define TCP_RESET_LOW_CYC    16
`define TCP_CONV_CYC         16'h2000
`define TCP_NV_SET_REPEATS   375

`endif

// ===== design/tcp_pkg.sv
/*
  Types of the test command port.
  Assumes tcp_regs.svh is on the include path.
*/
package tcp_pkg;
  `include "tcp_regs.svh"

  typedef enum logic [1:0] {
    TCP_IDLE,
    TCP_SHIFT,
    TCP_EXEC
  } tcp_rx_state_t;

  typedef enum logic [1:0] {
    TCP_CV_IDLE,
    TCP_CV_LOAD,
    TCP_CV_RUN
  } tcp_conv_state_t;

endpackage : tcp_pkg

// ===== test/tcp_command_port_checker.sv
/*
  Port checker for the test command port.
  Bound onto tcp_command_port; sees only its ports.
*/
`timescale 1ns/1ps
module tcp_command_port_checker
  import tcp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        test_mode_pin,
  input wire logic        frame_rstn_pin,
  input wire logic        observe_ready,
  input wire logic        sdio_o,
  input wire logic        sdio_oe,
  input wire logic        serial_observe_oe,
  input wire logic        serial_observe_out,
  input wire logic [2:0]  bias_trim_setting,
  input wire logic [1:0]  front_gain_setting,
  input wire logic        amp_enable,
  input wire logic [2:0]  thermal_bias_trim,
  input wire logic        conv_busy,
  input wire logic        coeff_valid,
  input wire logic [15:0] coeff_data,
  input wire logic [2:0]  coeff_index
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  logic [5:0] rise_cnt_q;
  // Cycles since the frame pin went high, saturating
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rise_cnt_q <= 6'h00;
    else if (!frame_rstn_pin) rise_cnt_q <= 6'h00;
    else if (rise_cnt_q != 6'h3F) rise_cnt_q <= rise_cnt_q + 6'h01;
  end

  property p_late_start;
    $rose(conv_busy) |-> frame_rstn_pin && rise_cnt_q >= 6'h22;
  endproperty
  a_late_start: assert property (p_late_start) else $error("start before 32 bits");
  property p_bank_clear;
    (test_mode_pin && !frame_rstn_pin)[*7] |-> bias_trim_setting == 3'h0
      && front_gain_setting == 2'h0 && !amp_enable && thermal_bias_trim == 3'h0;
  endproperty
  a_bank_clear: assert property (p_bank_clear) else $error("bank not cleared");
  property p_abort;
    (test_mode_pin && !frame_rstn_pin)[*7] |-> !conv_busy;
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");
  property p_oe_pair;
    sdio_oe == serial_observe_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("serial enables differ");
  property p_tag_line;
    sdio_oe |-> sdio_o == ($past(coeff_index[0]) && $past(coeff_valid));
  endproperty
  a_tag_line: assert property (p_tag_line) else $error("word tag wrong");
  property p_hold;
    coeff_valid && !observe_ready |=> coeff_valid && $stable(coeff_data)
      && $stable(coeff_index);
  endproperty
  a_hold: assert property (p_hold) else $error("word lost in stall");
  property p_ser_msb;
    coeff_valid && ($rose(coeff_valid) || $changed(coeff_data)) |=>
      serial_observe_out == $past(coeff_data[15]);
  endproperty
  a_ser_msb: assert property (p_ser_msb) else $error("word not sent top bit first");
  property p_oe_in_conv;
    $rose(serial_observe_oe) |-> conv_busy;
  endproperty
  a_oe_in_conv: assert property (p_oe_in_conv) else $error("outputs on while idle");
  property p_reset_quiet;
    $rose(rstn) |-> !conv_busy && !coeff_valid && !sdio_oe && !amp_enable;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy at reset");

  c_stall: cover property (coeff_valid && !observe_ready);
  c_start: cover property ($rose(conv_busy));
  c_obs: cover property ($rose(serial_observe_oe));
endmodule : tcp_command_port_checker

bind tcp_command_port tcp_command_port_checker u_chk (
  .mclk(mclk), .rstn(rstn), .test_mode_pin(test_mode_pin),
  .frame_rstn_pin(frame_rstn_pin), .observe_ready(observe_ready), .sdio_o(sdio_o),
  .sdio_oe(sdio_oe), .serial_observe_oe(serial_observe_oe),
  .serial_observe_out(serial_observe_out),
  .bias_trim_setting(bias_trim_setting), .front_gain_setting(front_gain_setting),
  .amp_enable(amp_enable), .thermal_bias_trim(thermal_bias_trim),
  .conv_busy(conv_busy), .coeff_valid(coeff_valid), .coeff_data(coeff_data),
  .coeff_index(coeff_index)
);

// ===== test/tcp_tester.sv
/*
  Tester model: test mode, frame pin and serial command line.
  Assumes the bench resolves the shared serial line.
*/
`timescale 1ns/1ps
module tcp_tester #(
  parameter int LOW_CYC = 18
) (
  input  wire logic mclk,
  output logic      test_mode_pin,
  output logic      frame_rstn_pin,
  output logic      sdio_drv
);
  logic tx_on;
  initial begin
    test_mode_pin = 1'b1;
    frame_rstn_pin = 1'b0;
    sdio_drv = 1'b0;
    tx_on = 1'b0;
  end
  // Released line wanders so a stale bit never passes for data
  always @(negedge mclk) if (!tx_on) sdio_drv <= ~sdio_drv;
  // One frame: reset low, rise, then 32 bits MSB first after falling edges
  task automatic send_cmd(input logic [31:0] w);
    @(negedge mclk);
    tx_on = 1'b1;
    frame_rstn_pin <= 1'b0;
    repeat (LOW_CYC) @(negedge mclk);
    frame_rstn_pin <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      @(negedge mclk);
      sdio_drv <= w[i];
    end
    @(negedge mclk);
    tx_on = 1'b0;
  endtask : send_cmd
endmodule : tcp_tester

// ===== test/tb_tcp_command_port.sv
/*
  Testbench of the test command port: tester model on the serial side,
  observation stream and configuration pins checked here.
  Assumes the tester model and the bound port checker are compiled alongside.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_tcp_command_port;
  import tcp_pkg::*;
  logic        mclk = 1'b0;
  logic        rstn, adc_sample_valid, observe_ready;
  logic [16:0] adc_sample;
  wire         test_mode_pin, frame_rstn_pin, sdio_drv, sdio_i;
  wire         sdio_o, sdio_oe, serial_observe_out, serial_observe_oe, amp_enable;
  wire [2:0]   bias_trim_setting, thermal_bias_trim, coeff_index;
  wire [1:0]   front_gain_setting;
  wire         conv_busy, coeff_valid;
  wire [15:0]  coeff_data;
  int          n_errors = 0;
  int          tests_run = 0;
  logic [15:0] wq[$];
  logic [2:0]  iq[$];
  logic [15:0] ea[9] = '{16'h0080, 16'h8001, 0, 0, 0, 0, 0, 16'h8000, 16'h7FFF};
  logic [15:0] ez[9] = '{0, 0, 0, 0, 0, 0, 0, 0, 16'h7FFF};
  logic [15:0] en[9] = '{0, 0, 0, 0, 0, 0, 0, 0, 16'h8000};

  always #10 mclk = ~mclk;
  // Shared serial line: device wins while it drives
  assign sdio_i = sdio_oe ? sdio_o : sdio_drv;
  // Receiver stalls every other cycle to exercise the buffer
  always @(negedge mclk) observe_ready <= ~observe_ready;
  always @(posedge mclk) if (coeff_valid && observe_ready) begin
    wq.push_back(coeff_data);
    iq.push_back(coeff_index);
  end

  tcp_tester u_tst (.mclk(mclk), .test_mode_pin(test_mode_pin),
    .frame_rstn_pin(frame_rstn_pin), .sdio_drv(sdio_drv));
  tcp_command_port #(.CONV_CYC(16'h0020)) u_dut (
    .mclk(mclk), .rstn(rstn), .test_mode_pin(test_mode_pin),
    .frame_rstn_pin(frame_rstn_pin), .sdio_i(sdio_i), .adc_sample_valid(adc_sample_valid),
    .adc_sample(adc_sample), .observe_ready(observe_ready), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .serial_observe_out(serial_observe_out),
    .serial_observe_oe(serial_observe_oe), .bias_trim_setting(bias_trim_setting),
    .front_gain_setting(front_gain_setting), .amp_enable(amp_enable),
    .thermal_bias_trim(thermal_bias_trim), .conv_busy(conv_busy),
    .coeff_valid(coeff_valid), .coeff_data(coeff_data), .coeff_index(coeff_index));

  // One framed command, then time for execution and config pins
  task automatic cmd(input logic [15:0] d, input logic [6:0] nva, input logic [2:0] ra,
                     input logic [3:0] op);
    u_tst.send_cmd({d, 1'b0, nva, 1'b0, ra, op});
    repeat (8) @(negedge mclk);
  endtask : cmd

  task automatic cfg(input logic [2:0] b, input logic [1:0] g, input logic a,
                     input logic [2:0] t);
    `CHK("bias_trim", b, bias_trim_setting)
    `CHK("front_gain", g, front_gain_setting)
    `CHK("amp_enable", a, amp_enable)
    `CHK("thermal_trim", t, thermal_bias_trim)
  endtask : cfg

  // Start a conversion and compare the nine observation words
  task automatic conv(input logic [3:0] op, input logic [15:0] e[9]);
    wq.delete();
    iq.delete();
    cmd(16'h0000, 7'h00, 3'h0, op);
    for (int k = 0; k < 400 && wq.size() < 9; k++) @(negedge mclk);
    `CHK("word_count", 9, wq.size())
    for (int k = 0; k < 9 && k < wq.size(); k++) begin
      `CHK("coeff_data", e[k], wq[k])
      `CHK("coeff_index", (k == 8) ? 3'h0 : 3'(k), iq[k])
    end
  endtask : conv

  // Conversion with observation off: lines stay released
  task automatic quiet(input logic [3:0] op, input logic busy);
    logic seen;
    seen = 1'b0;
    cmd(16'h0000, 7'h00, 3'h0, op);
    repeat (100) begin
      @(negedge mclk);
      seen = seen | sdio_oe | serial_observe_oe;
    end
    `CHK("serial_oe", 1'b0, seen)
    `CHK("conv_busy", busy, conv_busy)
  endtask : quiet

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial begin
    rstn = 1'b0;
    adc_sample_valid = 1'b1;
    adc_sample = 17'h08000; // Positive overflow: guard and sign differ
    observe_ready = 1'b0;
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    cmd(16'h0A9D, 7'h00, 3'h0, 4'h1);
    cfg(3'h5, 2'h3, 1'b1, 3'h5);
    cmd(16'h0A9D, 7'h00, 3'h3, 4'h1);
    cfg(3'h0, 2'h0, 1'b0, 3'h0);
    foreach (ea[i]) if (i < 4) cmd(16'hFFFF, i == 0 ? 7'h10 : i == 1 ? 7'h1F :
      i == 2 ? 7'h7F : 7'h07, 3'h0, 4'h2);
    cfg(3'h0, 2'h0, 1'b0, 3'h0);
    cmd(16'h0000, 7'h20, 3'h0, 4'h0);
    conv(4'hA, ea);
    cfg(3'h0, 2'h0, 1'b1, 3'h0);
    conv(4'h8, ez);
    cmd(16'h0000, 7'h0F, 3'h0, 4'h2);
    quiet(4'hE, 1'b1);
    cfg(3'h0, 2'h0, 1'b1, 3'h0);
    cmd(16'h0000, 7'h00, 3'h0, 4'h0);
    repeat (375) cmd(16'h0000, 7'h00, 3'h0, 4'h4);
    cmd(16'h0000, 7'h00, 3'h0, 4'h0);
    adc_sample = 17'h10000; // Negative overflow: guard set, sign clear
    conv(4'hA, en);
    quiet(4'hC, 1'b0);
    stop_test();
  end

  // Watchdog: the 375-frame erase dominates, about 25k clocks in all
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    stop_test();
  end
endmodule : tb_tcp_command_port
